// ---- rtl/bmar_battery_alarm.sv ----
// battery monitor with alarm reporting through objects, emergency and panel
`timescale 1ns/10ps
module bmar_battery_alarm
	import bmar_pkg::*;
#(
	parameter logic [CNT_W-1:0] P_PWRUP_CYC = CNT_W'(PWRUP_MS * CLK_KHZ),
	parameter logic [CNT_W-1:0] P_WINDOW_CYC = CNT_W'(WINDOW_MS * CLK_KHZ),
	parameter logic [CNT_W-1:0] P_CHAR_CYC = CNT_W'(CHAR_MS * CLK_KHZ)
) (
	// clock and reset (reset is the control-power cycle)
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	// stored parameter value restored at power-up
	input wire logic [15:0] i_param_nv,
	// battery sense
	input wire logic [11:0] i_batt_mv,
	// other drive alarm sources
	input wire logic i_ext_alarm,
	input wire logic [11:0] i_ext_code,
	input wire logic i_comm_fail,
	// object access from the fieldbus
	input wire logic i_obj_rd,
	input wire logic i_obj_wr,
	input wire logic [15:0] i_obj_index,
	input wire logic [15:0] i_obj_wdata,
	output logic o_obj_ack,
	output logic o_obj_err,
	output logic [15:0] o_obj_rdata,
	// emergency message
	input wire logic i_link_ok,
	input wire logic i_emcy_ready,
	output logic o_emcy_valid,
	output logic [15:0] o_emcy_code,
	// pins and panel
	output logic o_servo_alarm_output,
	output logic [7:0] o_panel_char
);

	function automatic logic [7:0] hex_char(input logic [3:0] nib);
		hex_char = (nib < 4'hA) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
	endfunction

	bmar_state_t state_r, state_nxt;
	logic [CNT_W-1:0] tmr_r, tmr_nxt;
	logic started_r;
	logic [15:0] param_r;
	logic [3:0] mode_r;
	logic batt_alarm_r, batt_warn_r;
	logic [11:0] shown_code_r;
	logic emcy_pend_r;
	logic [CNT_W-1:0] char_tmr_r;
	logic [2:0] char_idx_r;
	logic obj_ack_r, obj_err_r;
	logic [15:0] obj_rdata_r;
	logic [15:0] emcy_code_r;
	logic servo_alm_r;
	logic [7:0] panel_r;

	// monitoring phase
	wire batt_low = (i_batt_mv <= BATT_LOW_MV);
	wire in_pwrup = (state_r == ST_PWRUP);
	wire checking = (state_r == ST_WINDOW) || (state_r == ST_CONT);
	wire warn_mode = (mode_r == MODE_WARN);
	wire set_alarm = started_r && checking && batt_low && !warn_mode;
	wire set_warn = started_r && checking && batt_low && warn_mode;
	wire tmr_done = (tmr_r == '0);

	always_comb begin
		state_nxt = state_r;
		tmr_nxt = tmr_done ? tmr_r : tmr_r - CNT_W'(1);
		unique case (state_r)
			ST_PWRUP: begin
				if (started_r && tmr_done) begin
					state_nxt = warn_mode ? ST_CONT : ST_WINDOW;
					tmr_nxt = P_WINDOW_CYC;
				end
			end
			ST_WINDOW: begin
				if (tmr_done) begin
					state_nxt = ST_DONE;
				end
			end
			ST_CONT: begin
				state_nxt = ST_CONT;
			end
			ST_DONE: begin
				state_nxt = ST_DONE;
			end
		endcase
	end

	// stored parameter and active mode are caught once after power-up
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			started_r <= 1'b0;
			param_r <= MODE_PARAM_RST;
			mode_r <= MODE_ALARM;
			state_r <= ST_PWRUP;
			tmr_r <= '0;
		end else begin
			started_r <= 1'b1;
			state_r <= state_nxt;
			if (!started_r) begin
				param_r <= i_param_nv;
				mode_r <= i_param_nv[MODE_DIGIT_LSB +: MODE_DIGIT_W];
				tmr_r <= P_PWRUP_CYC;
			end else begin
				tmr_r <= tmr_nxt;
				if (i_obj_wr && (i_obj_index == IDX_MODE_PARAM)) begin
					param_r <= i_obj_wdata;
				end
			end
		end
	end

	// only the power cycle clears these, voltage recovery does not
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			batt_alarm_r <= 1'b0;
			batt_warn_r <= 1'b0;
		end else begin
			batt_alarm_r <= batt_alarm_r | set_alarm;
			batt_warn_r <= batt_warn_r | set_warn;
		end
	end

	// active alarm selection; other drive alarms take priority
	wire any_alarm = batt_alarm_r || i_ext_alarm;
	wire [11:0] alarm_code = i_ext_alarm ? i_ext_code :
		(batt_alarm_r ? CODE_BATT_ALARM : CODE_NONE);
	wire [11:0] disp_code = any_alarm ? alarm_code : (batt_warn_r ? CODE_BATT_WARN : CODE_NONE);
	wire disp_on = any_alarm || batt_warn_r;
	wire new_alarm = any_alarm && (alarm_code != shown_code_r);
	wire [15:0] status_word = (16'(any_alarm) << STAT_FAULT_BIT)
		| (16'(batt_warn_r) << STAT_WARN_BIT);

	// message stays pending while the link is down; only a newer alarm replaces it
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			shown_code_r <= CODE_NONE;
			emcy_pend_r <= 1'b0;
			emcy_code_r <= 16'h0000;
			o_emcy_valid <= 1'b0;
		end else begin
			shown_code_r <= any_alarm ? alarm_code : CODE_NONE;
			if (new_alarm) begin
				emcy_pend_r <= 1'b1;
				emcy_code_r <= {4'h0, alarm_code};
			end else if (o_emcy_valid && i_emcy_ready) begin
				emcy_pend_r <= 1'b0;
			end
			o_emcy_valid <= (new_alarm || (emcy_pend_r && !(o_emcy_valid && i_emcy_ready)))
				&& i_link_ok;
		end
	end
	assign o_emcy_code = emcy_code_r;

	// object access answers one cycle after the request
	wire idx_hit = (i_obj_index == IDX_MODE_PARAM) || (i_obj_index == IDX_ERR_CODE)
		|| (i_obj_index == IDX_STATUS);
	wire wr_bad = i_obj_wr && (i_obj_index != IDX_MODE_PARAM);
	wire rd_bad = i_obj_rd && !idx_hit;
	wire [15:0] rd_mux = (i_obj_index == IDX_MODE_PARAM) ? param_r :
		(i_obj_index == IDX_ERR_CODE) ? {4'h0, alarm_code} :
		(i_obj_index == IDX_STATUS) ? status_word : 16'h0000;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			obj_ack_r <= 1'b0;
			obj_err_r <= 1'b0;
			obj_rdata_r <= 16'h0000;
		end else begin
			obj_ack_r <= started_r && (i_obj_rd || i_obj_wr);
			obj_err_r <= started_r && (rd_bad || wr_bad);
			obj_rdata_r <= (started_r && i_obj_rd) ? rd_mux : 16'h0000;
		end
	end
	assign o_obj_ack = obj_ack_r;
	assign o_obj_err = obj_err_r;
	assign o_obj_rdata = obj_rdata_r;

	// panel character stepping from a divider enable
	wire char_step = (char_tmr_r == '0);
	wire [7:0] code_char = (char_idx_r == 3'h0) ? CH_A :
		(char_idx_r == 3'h1) ? CH_DOT :
		(char_idx_r == 3'h2) ? hex_char(disp_code[11:8]) :
		(char_idx_r == 3'h3) ? hex_char(disp_code[7:4]) :
		(char_idx_r == 3'h4) ? hex_char(disp_code[3:0]) : CH_BLANK;
	wire [7:0] panel_nxt = i_comm_fail ? CH_DASH :
		(disp_on ? code_char : CH_BLANK);

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			char_tmr_r <= '0;
			char_idx_r <= 3'h0;
			panel_r <= CH_BLANK;
		end else begin
			panel_r <= panel_nxt;
			if (!disp_on) begin
				char_tmr_r <= P_CHAR_CYC;
				char_idx_r <= 3'h0;
			end else if (char_step) begin
				char_tmr_r <= P_CHAR_CYC;
				char_idx_r <= (char_idx_r == CHAR_LAST) ? 3'h0 : char_idx_r + 3'h1;
			end else begin
				char_tmr_r <= char_tmr_r - CNT_W'(1);
			end
		end
	end
	assign o_panel_char = panel_r;

	// servo alarm output: power-up interval and any active alarm
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			servo_alm_r <= 1'b1;
		end else begin
			servo_alm_r <= in_pwrup || any_alarm;
		end
	end
	assign o_servo_alarm_output = servo_alm_r;

endmodule

// ---- rtl/bmar_pkg.sv ----
// constants and register layout for the battery monitor and alarm report block
// Functional notes
// - Battery at or below about 2.7 V is flagged as alarm or warning.
// - Mode digit 0 (default) raises the battery alarm; digit changes need restart.
// - Mode digit 1 raises the battery warning instead of the alarm.
// - Servo alarm output asserted up to five seconds after control-power turn-on.
// - Alarm mode checks the battery only in a four-second window afterwards.
// - Alarm mode ignores battery drops after that window has ended.
// - Warning mode checks the battery continuously after the power-up interval.
// - Battery alarm clears only by cycling control power after replacement.
// - Status word bit 3 is 1 on any alarm, 0 in normal operation.
// - Error code object holds the code of the currently active alarm.
// - An emergency message goes to the controller whenever an alarm occurs; a battery alarm during an external alarm waits until that clears.
// - Panel shows the active alarm code one character at a time.
// - Internal communications failure shows a dash pattern instead of a number.
package bmar_pkg;
	// object indexes
	localparam logic [15:0] IDX_MODE_PARAM = 16'h2008;
	localparam logic [15:0] IDX_ERR_CODE = 16'h603F;
	localparam logic [15:0] IDX_STATUS = 16'h6041;
	// field positions
	localparam int MODE_DIGIT_LSB = 0;
	localparam int MODE_DIGIT_W = 4;
	localparam int STAT_FAULT_BIT = 3;
	localparam int STAT_WARN_BIT = 7;
	localparam logic [3:0] MODE_ALARM = 4'h0;
	localparam logic [3:0] MODE_WARN = 4'h1;
	localparam logic [15:0] MODE_PARAM_RST = 16'h0000;
	// alarm codes
	localparam logic [11:0] CODE_BATT_ALARM = 12'h830;
	localparam logic [11:0] CODE_BATT_WARN = 12'h930;
	localparam logic [11:0] CODE_NONE = 12'h000;
	// battery threshold in millivolts
	localparam logic [11:0] BATT_LOW_MV = 12'hA8C;
	// timing
	localparam int CLK_KHZ = 250000;
	localparam int PWRUP_MS = 5000;
	localparam int WINDOW_MS = 4000;
	localparam int CHAR_MS = 500;
	localparam int CNT_W = 32;
	// panel characters
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_DASH = 8'h2D;
	localparam logic [7:0] CH_BLANK = 8'h20;
	localparam logic [2:0] CHAR_LAST = 3'h5;
	typedef enum logic [1:0] {ST_PWRUP, ST_WINDOW, ST_CONT, ST_DONE} bmar_state_t;
endpackage

// ---- test/bmar_asserts.sv ----
// port assertions for the battery monitor block
`timescale 1ns/10ps
module bmar_asserts (
	input wire logic i_ref_clk, i_rstn, i_obj_rd, i_obj_wr, i_ext_alarm, i_comm_fail,
	input wire logic i_link_ok, i_emcy_ready,
	input wire logic [15:0] i_obj_index,
	input wire logic [11:0] i_ext_code,
	input wire logic o_obj_ack, o_obj_err, o_emcy_valid, o_servo_alarm_output,
	input wire logic [15:0] o_obj_rdata, o_emcy_code,
	input wire logic [7:0] o_panel_char
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	a_pwrup_alarm: assert property ($rose(i_rstn) |-> o_servo_alarm_output [*8])
		else $error("servo alarm short");
	a_obj_answer: assert property ($past(i_rstn) && (i_obj_rd || i_obj_wr) |=> o_obj_ack)
		else $error("no answer");
	a_ack_cause: assert property (o_obj_ack |-> $past(i_obj_rd) || $past(i_obj_wr))
		else $error("stray answer");
	a_unmapped_err: assert property ($past(i_rstn) && i_obj_rd &&
		!(i_obj_index inside {16'h2008, 16'h603F, 16'h6041}) |=> o_obj_err && o_obj_rdata == 16'h0)
		else $error("unmapped read");
	a_ro_write: assert property ($past(i_rstn) && i_obj_wr && i_obj_index != 16'h2008
		|=> o_obj_err) else $error("write accepted");
	a_comm_dash: assert property (i_comm_fail |=> o_panel_char == 8'h2D)
		else $error("no dash");
	a_emcy_hold: assert property (o_emcy_valid && !i_emcy_ready && i_link_ok |=> o_emcy_valid)
		else $error("message dropped");
	a_ext_emcy: assert property ($past(i_rstn) && $rose(i_ext_alarm) && i_link_ok |=>
		o_emcy_valid && o_emcy_code == {4'h0, $past(i_ext_code)}) else $error("no message");
endmodule
bind bmar_battery_alarm bmar_asserts i_bmar_asserts (.*);

// ---- test/bmar_battery_alarm_tb.sv ----
// self-checking bench for the battery monitor block
`timescale 1ns/10ps
module bmar_battery_alarm_tb;
	logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_ext_alarm = 1'b0, i_comm_fail = 1'b0;
	logic i_obj_rd = 1'b0, i_obj_wr = 1'b0, i_link_ok = 1'b1, slow = 1'b0;
	logic [15:0] i_param_nv = 16'h0000, i_obj_index = 16'h0000, i_obj_wdata = 16'h0000;
	logic [11:0] i_batt_mv = 12'hBB8, i_ext_code = 12'h123;
	wire o_obj_ack, o_obj_err, o_emcy_valid, o_servo_alarm_output, ready;
	wire [15:0] o_obj_rdata, o_emcy_code, last;
	wire [7:0] o_panel_char;
	int bad_count = 0, comparisons = 0;
	always #2 i_ref_clk = ~i_ref_clk;
	bmar_battery_alarm #(.P_PWRUP_CYC(20), .P_WINDOW_CYC(16), .P_CHAR_CYC(3))
		i_bmar_battery_alarm (.*, .i_emcy_ready(ready));
	bmar_host_model i_bmar_host_model (.i_ref_clk, .i_slow(slow), .i_emcy_valid(o_emcy_valid),
		.i_emcy_code(o_emcy_code), .o_emcy_ready(ready), .o_last_code(last));
	task automatic chk(input logic [17:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		if (bad_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic restart(input logic [15:0] nv, input logic [11:0] mv);
		@(posedge i_ref_clk);
		i_rstn <= 1'b0;
		i_param_nv <= nv;
		i_batt_mv <= mv;
		repeat (16) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		@(posedge i_ref_clk);
	endtask
	// writes send exp as data and expect zero read data back
	task automatic obj(input logic w, input logic [15:0] idx, exp, input logic err);
		@(posedge i_ref_clk);
		i_obj_rd <= !w;
		i_obj_wr <= w;
		i_obj_index <= idx;
		i_obj_wdata <= exp;
		@(posedge i_ref_clk);
		{i_obj_rd, i_obj_wr} <= 2'b00;
		#1 chk({o_obj_ack, o_obj_err, o_obj_rdata}, {1'b1, err, w ? 16'h0 : exp});
	endtask
	task automatic panel(input logic [7:0] d);
		logic [7:0] exp [6] = '{8'h41, 8'h2E, d, 8'h33, 8'h30, 8'h20};
		repeat (100) if (o_panel_char !== 8'h41) @(posedge i_ref_clk) #1;
		foreach (exp[i]) begin
			chk(18'(o_panel_char), 18'(exp[i]));
			repeat (4) @(posedge i_ref_clk);
			#1;
		end
	endtask
	task automatic t_alarm;
		restart(16'h0000, 12'hA8C);
		#1 chk(18'(o_servo_alarm_output), 18'h00001);
		obj(1'b0, 16'h6041, 16'h0000, 1'b0);
		obj(1'b0, 16'h1234, 16'h0000, 1'b1);
		obj(1'b1, 16'h6041, 16'hFFFF, 1'b1);
		obj(1'b1, 16'h2008, 16'h0001, 1'b0);
		obj(1'b0, 16'h2008, 16'h0001, 1'b0);
		panel(8'h38);
		obj(1'b0, 16'h603F, 16'h0830, 1'b0);
		obj(1'b0, 16'h6041, 16'h0008, 1'b0);
		chk(18'(last), 18'h00830);
	endtask
	task automatic t_late;
		restart(16'h0000, 12'hA8D);
		repeat (60) @(posedge i_ref_clk);
		i_batt_mv <= 12'h000;
		repeat (20) @(posedge i_ref_clk);
		#1 chk(18'(o_servo_alarm_output), 18'h00000);
		obj(1'b0, 16'h6041, 16'h0000, 1'b0);
		obj(1'b0, 16'h603F, 16'h0000, 1'b0);
	endtask
	task automatic t_warn;
		restart(16'h0001, 12'hBB8);
		repeat (200) @(posedge i_ref_clk);
		i_batt_mv <= 12'hA8C;
		#1 panel(8'h39);
		obj(1'b0, 16'h6041, 16'h0080, 1'b0);
		obj(1'b0, 16'h603F, 16'h0000, 1'b0);
		chk(18'(o_servo_alarm_output), 18'h00000);
	endtask
	// second alarm raised with the link down must wait and then be offered
	task automatic t_ext;
		@(posedge i_ref_clk);
		slow <= 1'b1;
		i_ext_alarm <= 1'b1;
		repeat (20) @(posedge i_ref_clk);
		#1 chk(18'(last), 18'h00123);
		obj(1'b0, 16'h603F, 16'h0123, 1'b0);
		@(posedge i_ref_clk);
		i_link_ok <= 1'b0;
		i_ext_code <= 12'h456;
		repeat (10) @(posedge i_ref_clk);
		#1 chk(18'(o_emcy_valid), 18'h00000);
		@(posedge i_ref_clk);
		i_link_ok <= 1'b1;
		repeat (10) @(posedge i_ref_clk);
		#1 chk(18'(last), 18'h00456);
		@(posedge i_ref_clk);
		i_comm_fail <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		#1 chk(18'(o_panel_char), 18'h0002D);
	endtask
	initial begin
		t_alarm;
		t_late;
		t_warn;
		t_ext;
		summarize;
	end
	// the tests need well under a thousand cycles
	initial begin
		#20000;
		bad_count++;
		summarize;
	end
endmodule

// ---- test/bmar_host_model.sv ----
// host controller model taking emergency messages
`timescale 1ns/10ps
module bmar_host_model (
	// clock and pace
	input wire logic i_ref_clk,
	input wire logic i_slow,
	// emergency channel
	input wire logic i_emcy_valid,
	input wire logic [15:0] i_emcy_code,
	output logic o_emcy_ready = 1'b0,
	output logic [15:0] o_last_code
);
	// a slow host listens every other cycle, so offers must wait
	always @(posedge i_ref_clk) begin
		o_emcy_ready <= !i_slow || !o_emcy_ready;
		if (i_emcy_valid && o_emcy_ready)
			o_last_code <= i_emcy_code;
	end
endmodule
